// ---- bench/awc_conv_model.sv ----
// converter end-of-conversion model feeding the window comparator
module awc_conv_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [15:0] word,
	output logic convDone,
	output logic [15:0] convData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		convDone = 1'b0;
		convData = 16'h0000;
	end
	// result only valid with the done pulse, scrambled between
	always @(negedge mclk) begin
		convDone <= go;
		convData <= go ? word : ~convData;
	end
endmodule // awc_conv_model

// ---- bench/awc_window_comparator_tb.sv ----
// self-checking bench for the window comparator
`include "awc_cfg.svh"
module awc_window_comparator_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, sys_rst = 1, sfrWrEn = 0, sfrRdEn = 0, go = 0, rdSeen = 0, cvSeen = 0, fl = 0;
	logic [7:0] sfrAddr = 8'h00, sfrPage = 8'h00, sfrWrData = 8'h00, sfrRdData;
	logic [15:0] word = 16'h0000, convData, lt, gt, d;
	logic convDone, windowCompareFlag;
	logic [31:0] lim;
	awc_pkg::awc_mode_t inputMode = awc_pkg::AWC_MODE_SINGLE;
	logic [7:0] aL[4] = '{`AWC_ADDR_LTH, `AWC_ADDR_LTL, `AWC_ADDR_GTH, `AWC_ADDR_GTL};
	logic [31:0] fig[3] = '{32'h1000FFFF, 32'hFFFF1000, 32'h12341234};
	logic [7:0] expQ[$];
	int nErrors = 0, nCompared = 0;
	always #25 mclk = ~mclk;
	awc_window_comparator dut (.mclk(mclk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
		.sfrPage(sfrPage), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData),
		.convDone(convDone), .convData(convData), .inputMode(inputMode),
		.sfrRdData(sfrRdData), .windowCompareFlag(windowCompareFlag));
	awc_conv_model conv (.mclk(mclk), .go(go), .word(word), .convDone(convDone),
		.convData(convData));
	// =====================================================
	// tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		nCompared++;
		if (g !== e) begin
			nErrors++;
			$display("wrong value at %0t: saw %h, want %h", $time, g, e);
		end
	endtask
	task automatic tallyAndFinish();
		if (nErrors == 0 && nCompared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic hit(input logic [15:0] x, g, l, input logic s);
		logic [15:0] m;
		m = {s, 15'h0000};
		x ^= m;
		g ^= m;
		l ^= m;
		return (l > g) ? (g < x && x < l) : (x < l || x > g);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk);
		sfrAddr = a;
		sfrWrData = v;
		sfrWrEn = 1;
		@(negedge mclk);
		sfrWrEn = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		sfrAddr = a;
		sfrRdEn = 1;
		expQ.push_back(e);
		@(negedge mclk);
		sfrRdEn = 0;
	endtask
	// write, then read the same byte back in the very next cycle
	task automatic wrrd(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk);
		sfrAddr = a;
		sfrWrData = v;
		sfrWrEn = 1;
		@(negedge mclk);
		sfrWrEn = 0;
		sfrRdEn = 1;
		expQ.push_back(v);
		@(negedge mclk);
		sfrRdEn = 0;
	endtask
	task automatic cv(input logic [15:0] x);
		@(negedge mclk);
		go <= 1'b1;
		word <= x;
		@(negedge mclk);
		go <= 1'b0;
		fl = fl | hit(x, gt, lt, inputMode);
		expQ.push_back({7'h00, fl});
	endtask
	// =====================================================
	// result watcher
	always @(posedge mclk) begin
		rdSeen <= sfrRdEn;
		cvSeen <= convDone;
	end
	always @(negedge mclk) begin
		if (rdSeen)
			chk(sfrRdData, expQ.pop_front());
		if (cvSeen)
			chk({7'h00, windowCompareFlag}, expQ.pop_front());
	end
	initial begin
		repeat (20000) @(posedge mclk);
		nErrors++;
		tallyAndFinish();
	end
	// =====================================================
	// main sequence
	initial begin
		void'($urandom(59));
		repeat (16) @(negedge mclk);
		sys_rst = 0;
		foreach (aL[i])
			rd(aL[i], 8'h00);
		rd(`AWC_ADDR_CTRL, 8'h00);
		rd(8'h10, 8'h00);
		foreach (aL[i]) begin
			d = 16'($urandom);
			wrrd(aL[i], d[7:0]);
			sfrPage = 8'h01;
			wr(aL[i], d[15:8]);
			rd(aL[i], 8'h00);
			sfrPage = 8'h00;
			rd(aL[i], d[7:0]);
		end
		for (int i = 0; i < 80; i++) begin
			lim = (i < 3) ? fig[i] : {16'($urandom), 16'($urandom)};
			{lt, gt} = lim;
			inputMode = awc_pkg::awc_mode_t'(1'($urandom));
			foreach (aL[j])
				wr(aL[j], lim[31 - 8 * j -: 8]);
			case ($urandom % 5)
				0: d = lt;
				1: d = gt;
				2: d = lt - 16'h0001;
				3: d = gt + 16'h0001;
				default: d = 16'($urandom);
			endcase
			if (i % 2 == 0) begin
				wr(`AWC_ADDR_CTRL, 8'h00);
				fl = 0;
			end
			cv(d);
			rd(`AWC_ADDR_CTRL, {2'h0, fl, 5'h00});
		end
		// other control bits read zero; a written one sets the flag
		wr(`AWC_ADDR_CTRL, 8'hFF);
		rd(`AWC_ADDR_CTRL, 8'h20);
		// reset in mid-run returns limits and flag to zero
		@(negedge mclk);
		sys_rst = 1;
		repeat (2) @(negedge mclk);
		sys_rst = 0;
		rd(`AWC_ADDR_LTH, 8'h00);
		rd(`AWC_ADDR_GTL, 8'h00);
		rd(`AWC_ADDR_CTRL, 8'h00);
		repeat (2) @(negedge mclk);
		tallyAndFinish();
	end
endmodule // awc_window_comparator_tb

// ---- design/awc_cfg.svh ----
// register map, reset values and field positions of the window comparator
`ifndef AWC_CFG_SVH
`define AWC_CFG_SVH

// =====================================================
// register addresses and pages
`define AWC_ADDR_LTH 8'hC7
`define AWC_ADDR_LTL 8'hC6
`define AWC_ADDR_GTH 8'hC5
`define AWC_ADDR_GTL 8'hC4
`define AWC_ADDR_CTRL 8'hE8
`define AWC_PAGE 8'h00

// =====================================================
// reset values and fields
`define AWC_LIM_RST 8'h00
`define AWC_FLAG_RST 1'b0
`define AWC_FLAG_BIT 5
`define AWC_RD_IDLE 8'h00

`endif

// ---- design/awc_limit_bank.sv ----
// four limit bytes held as the greater-than and less-than words
`include "awc_cfg.svh"

module awc_limit_bank (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic wrEn,
	input wire awc_pkg::awc_lim_sel_t wrSel,
	input wire logic [7:0] wrData,
	output logic [15:0] gtWord,
	output logic [15:0] ltWord
);

	logic [15:0] gt_q;
	logic [15:0] gt_d;
	logic [15:0] lt_q;
	logic [15:0] lt_d;

	// =====================================================
	// byte writes into the words
	always_comb begin
		gt_d = gt_q;
		lt_d = lt_q;
		if (wrEn) begin
			case (wrSel)
				awc_pkg::AWC_LIM_GTL: gt_d[7:0] = wrData;
				awc_pkg::AWC_LIM_GTH: gt_d[15:8] = wrData;
				awc_pkg::AWC_LIM_LTL: lt_d[7:0] = wrData;
				awc_pkg::AWC_LIM_LTH: lt_d[15:8] = wrData;
				default: gt_d = gt_q;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gt_q <= {`AWC_LIM_RST, `AWC_LIM_RST};
			lt_q <= {`AWC_LIM_RST, `AWC_LIM_RST};
		end else begin
			gt_q <= gt_d;
			lt_q <= lt_d;
		end
	end

	assign gtWord = gt_q;
	assign ltWord = lt_q;

endmodule // awc_limit_bank

// ---- design/awc_pkg.sv ----
// types shared by the window comparator files
package awc_pkg;

	typedef enum logic {
		AWC_MODE_SINGLE = 1'b0,
		AWC_MODE_DIFF = 1'b1
	} awc_mode_t;

	typedef enum logic [1:0] {
		AWC_LIM_GTL = 2'h0,
		AWC_LIM_GTH = 2'h1,
		AWC_LIM_LTL = 2'h3,
		AWC_LIM_LTH = 2'h2
	} awc_lim_sel_t;

endpackage

// ---- design/awc_window_comparator.sv ----
// window comparator on the first converter result, with its register port
//
// Contract
// - compare every new result against both limits
// - record hit in pollable window compare flag
// - limit words built from two byte registers
// - single-ended compares the first converter word
// - differential compares the combined result word
// - inside or outside chosen by limit order
// - evaluate and set flag at conversion end
// - low above high: flag inside the window
// - high above low: flag outside the window
// - differential data compared as signed values
// - low-limit high byte at C7, resets zero
// - low-limit low byte read-write register
`include "awc_cfg.svh"

module awc_window_comparator (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrPage,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrWrData,
	input wire logic convDone,
	input wire logic [15:0] convData,
	input wire awc_pkg::awc_mode_t inputMode,
	output logic [7:0] sfrRdData,
	output logic windowCompareFlag
);

	logic [15:0] gtWord;
	logic [15:0] ltWord;
	logic limHit;
	logic limWr;
	logic ctrlHit;
	awc_pkg::awc_lim_sel_t limSel;
	logic winHit;
	logic flag_q;
	logic flag_d;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;

	// =====================================================
	// window test
	// signed compare is done by flipping the sign bit, then comparing unsigned
	function automatic logic windowHit(
		input logic [15:0] d,
		input logic [15:0] gt,
		input logic [15:0] lt,
		input logic sgn
	);
		logic [15:0] dd;
		logic [15:0] gg;
		logic [15:0] ll;
		logic above;
		logic below;
		dd = d ^ {sgn, 15'h0000};
		gg = gt ^ {sgn, 15'h0000};
		ll = lt ^ {sgn, 15'h0000};
		above = dd > gg;
		below = dd < ll;
		if (ll > gg) begin
			return above && below;
		end else begin
			return above || below;
		end
	endfunction

	always_comb begin
		// the converter side supplies the word matching the mode
		winHit = windowHit(convData, gtWord, ltWord, inputMode == awc_pkg::AWC_MODE_DIFF);
	end

	// =====================================================
	// address decode
	always_comb begin
		limHit = 1'b0;
		ctrlHit = 1'b0;
		limSel = awc_pkg::AWC_LIM_GTL;
		if (sfrPage != `AWC_PAGE) begin
			limHit = 1'b0;
		end else if (sfrAddr == `AWC_ADDR_LTH) begin
			limHit = 1'b1;
			limSel = awc_pkg::AWC_LIM_LTH;
		end else if (sfrAddr == `AWC_ADDR_LTL) begin
			limHit = 1'b1;
			limSel = awc_pkg::AWC_LIM_LTL;
		end else if (sfrAddr == `AWC_ADDR_GTH) begin
			limHit = 1'b1;
			limSel = awc_pkg::AWC_LIM_GTH;
		end else if (sfrAddr == `AWC_ADDR_GTL) begin
			limHit = 1'b1;
			limSel = awc_pkg::AWC_LIM_GTL;
		end else if (sfrAddr == `AWC_ADDR_CTRL) begin
			ctrlHit = 1'b1;
		end
		limWr = sfrWrEn && limHit;
	end

	awc_limit_bank uBank (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.wrEn(limWr),
		.wrSel(limSel),
		.wrData(sfrWrData),
		.gtWord(gtWord),
		.ltWord(ltWord)
	);

	// =====================================================
	// flag and read data
	// a hit in the same cycle as a software clear wins
	always_comb begin
		flag_d = flag_q;
		if (sfrWrEn && ctrlHit) begin
			flag_d = sfrWrData[`AWC_FLAG_BIT];
		end
		if (convDone && winHit) begin
			flag_d = 1'b1;
		end
		rdData_d = rdData_q;
		if (sfrRdEn) begin
			rdData_d = `AWC_RD_IDLE;
			if (ctrlHit) begin
				rdData_d[`AWC_FLAG_BIT] = flag_q;
			end else if (limHit) begin
				case (limSel)
					awc_pkg::AWC_LIM_LTH: rdData_d = ltWord[15:8];
					awc_pkg::AWC_LIM_LTL: rdData_d = ltWord[7:0];
					awc_pkg::AWC_LIM_GTH: rdData_d = gtWord[15:8];
					default: rdData_d = gtWord[7:0];
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flag_q <= `AWC_FLAG_RST;
			rdData_q <= `AWC_RD_IDLE;
		end else begin
			flag_q <= flag_d;
			rdData_q <= rdData_d;
		end
	end

	assign windowCompareFlag = flag_q;
	assign sfrRdData = rdData_q;

	// =====================================================
	// checks
	logic ctrlWr;
	assign ctrlWr = sfrWrEn && sfrPage == `AWC_PAGE && sfrAddr == `AWC_ADDR_CTRL;

	sequence seqWriteLth;
		sfrWrEn && sfrPage == `AWC_PAGE && sfrAddr == `AWC_ADDR_LTH;
	endsequence

	sequence seqReadLth;
		sfrRdEn && !sfrWrEn && sfrPage == `AWC_PAGE && sfrAddr == `AWC_ADDR_LTH;
	endsequence

	AST_HIT_SETS_FLAG:
	assert property (@(posedge mclk) disable iff (sys_rst) convDone && winHit |=> windowCompareFlag)
		else $error("window hit at conversion end did not set flag");

	AST_FLAG_HOLDS:
	assert property (@(posedge mclk) disable iff (sys_rst)
		!convDone && !ctrlWr |=> $stable(windowCompareFlag))
		else $error("flag changed without a cause");

	AST_INSIDE_SINGLE:
	assert property (@(posedge mclk) disable iff (sys_rst)
		convDone && inputMode == awc_pkg::AWC_MODE_SINGLE && ltWord > gtWord
		&& convData < ltWord && convData > gtWord |=> windowCompareFlag)
		else $error("inside-window result did not set flag");

	AST_INSIDE_MISS:
	assert property (@(posedge mclk) disable iff (sys_rst)
		convDone && inputMode == awc_pkg::AWC_MODE_SINGLE && ltWord > gtWord
		&& convData >= ltWord && !windowCompareFlag && !ctrlWr |=> !windowCompareFlag)
		else $error("result above low limit set flag in inside mode");

	AST_OUTSIDE_SINGLE:
	assert property (@(posedge mclk) disable iff (sys_rst)
		convDone && inputMode == awc_pkg::AWC_MODE_SINGLE && gtWord > ltWord
		&& (convData < ltWord || convData > gtWord) |=> windowCompareFlag)
		else $error("outside-window result did not set flag");

	AST_SIGNED_DIFF:
	assert property (@(posedge mclk) disable iff (sys_rst)
		convDone && inputMode == awc_pkg::AWC_MODE_DIFF
		&& $signed(ltWord) > $signed(gtWord) && $signed(convData) < $signed(ltWord)
		&& $signed(convData) > $signed(gtWord) |=> windowCompareFlag)
		else $error("signed differential hit did not set flag");

	AST_CLEAR:
	assert property (@(posedge mclk) disable iff (sys_rst)
		ctrlWr && !sfrWrData[`AWC_FLAG_BIT] && !convDone |=> !windowCompareFlag)
		else $error("software clear did not clear flag");

	AST_LTH_WRITE:
	assert property (@(posedge mclk) disable iff (sys_rst)
		seqWriteLth |=> ltWord[15:8] == $past(sfrWrData))
		else $error("low-limit high byte not written");

	AST_LTH_READ:
	assert property (@(posedge mclk) disable iff (sys_rst)
		seqWriteLth ##1 seqReadLth |=> sfrRdData == $past(sfrWrData, 2))
		else $error("low-limit high byte read back wrong");

	AST_LTL_WRITE:
	assert property (@(posedge mclk) disable iff (sys_rst)
		sfrWrEn && sfrPage == `AWC_PAGE && sfrAddr == `AWC_ADDR_LTL
		|=> ltWord[7:0] == $past(sfrWrData))
		else $error("low-limit low byte not written");

	AST_RESET_LIMITS:
	assert property (@(posedge mclk) sys_rst |=> ltWord == 16'h0000 && !windowCompareFlag)
		else $error("limits or flag not cleared by reset");

endmodule // awc_window_comparator
